// *** design/rol_pkg.sv ***
// Constants of the rail order log and auto-mask control register bank.
// Assumes a register access port driven by an I2C front end elsewhere.
// Functional notes
// - Cutoff code selects 250 Hz..4 kHz, default 1 kHz
// - Self-test bit 7 high requests self-test
// - Record trigger starts recording, reads zero
// - Transition select picks one of four edges
// - Recorded order mismatch versus expected is fault
// - Timestamp release clears ready and overrun flags
// - Power-on release clears its ready, overrun
// - Power-off release clears its ready, overrun
// - Wake release clears its ready, overrun
// - Doze release clears its ready, overrun
// - Rise mask suppresses channel interrupts on rise
// - Fall mask suppresses channel interrupts on fall
// - Masks release after programmed timeout plus one, in milliseconds
package rol_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ROL_OFS_CUTOFF   = 8'h75;
  localparam logic [7:0] ROL_OFS_SELFTEST = 8'h9F;
  localparam logic [7:0] ROL_OFS_LOGCTL   = 8'hA0;
  localparam logic [7:0] ROL_OFS_RISEMSK  = 8'hA1;
  localparam logic [7:0] ROL_OFS_FALLMSK  = 8'hA2;
  // ==========================================================
  // Field positions
  localparam int ROL_BIT_SELFTEST = 7;
  localparam int ROL_BIT_TRIGGER  = 7;
  localparam int ROL_SEL_HI       = 6;
  localparam int ROL_SEL_LO       = 5;
  localparam int ROL_BIT_TS_REL   = 4;
  localparam int ROL_BIT_ON_REL   = 3;
  localparam int ROL_BIT_OFF_REL  = 2;
  localparam int ROL_BIT_WAKE_REL = 1;
  localparam int ROL_BIT_DOZE_REL = 0;
  // ==========================================================
  // Reset values and codes
  localparam logic [2:0] ROL_CUTOFF_RST = 3'h4;
  localparam logic [2:0] ROL_CUTOFF_MIN = 3'h2;
  localparam logic [2:0] ROL_CUTOFF_MAX = 3'h6;
  localparam logic [5:0] ROL_MASK_RST   = 6'h3F;
  localparam logic [1:0] ROL_SEL_RST    = 2'h0;
  // ==========================================================
  // Timing: 1 ms step at 10 MHz
  localparam int ROL_CLK_HZ     = 10000000;
  localparam int ROL_STEP_MS    = 1;
  localparam int ROL_STEP_CYC   = ROL_CLK_HZ / 1000 * ROL_STEP_MS;
  // Transition kinds
  typedef enum logic [1:0] {
    ROL_TR_PON  = 2'b00,
    ROL_TR_POFF = 2'b01,
    ROL_TR_WAKE = 2'b10,
    ROL_TR_DOZE = 2'b11
  } rol_trans_t;
endpackage : rol_pkg

// *** design/rol_flag.sv ***
// One ready/overrun flag pair of a recorded log.
// Assumes set pulses from the recorder, release strobe from registers.
`timescale 1ns/1ns
module rol_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Events
  input  wire logic done,     // Record completed
  input  wire logic release_s,// Host release strobe
  // Flags
  output logic      ready_q,
  output logic      over_q
);
  // ==========================================================
  // Set wins over clear so no completion is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
      over_q  <= 1'b0;
    end else begin
      if (done) begin
        ready_q <= 1'b1;
        over_q  <= over_q | ready_q;
      end else if (release_s) begin
        ready_q <= 1'b0;
        over_q  <= 1'b0;
      end
    end
  end
endmodule : rol_flag

// *** design/rol_ctl.sv ***
// Register bank for cutoff, self-test, order log control and auto-masks.
// Assumes a byte-wide register port from an I2C slave, synchronous inputs.
`timescale 1ns/1ns
module rol_ctl (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Configuration from elsewhere
  input  wire logic       timestamp_overwrite_allow,
  input  wire logic       log_overwrite_allow,
  input  wire logic [15:0] timeout_ms,
  // Transition inputs
  input  wire logic       run_request_pin,
  input  wire logic       sleep_pin,
  // Recorder interface
  input  wire logic [3:0] log_done,       // One per transition kind
  input  wire logic       ts_done,
  input  wire logic       order_mismatch,
  // Outputs
  output logic [2:0]      slow_path_cutoff_select,
  output logic            selftest_go,
  output logic            record_trigger,
  output rol_pkg::rol_trans_t transition_select,
  output logic [3:0]      log_ready,
  output logic [3:0]      log_overrun,
  output logic            timestamp_ready,
  output logic            timestamp_overrun,
  output logic            order_fault,
  output logic [5:0]      irq_suppress
);
  import rol_pkg::*;
  // ==========================================================
  // Register storage
  logic [2:0] cut_q;       // Cutoff code
  logic       st_q;        // Self-test request
  logic [1:0] sel_q;       // Transition select
  logic [5:0] rmsk_q;      // Rise auto-mask
  logic [5:0] fmsk_q;      // Fall auto-mask
  logic [7:0] rdata_q;     // Registered read data
  logic       trig_q;      // Record trigger strobe
  logic [3:0] rel_q;       // Log release strobes
  logic       tsrel_q;     // Timestamp release strobe
  logic       fault_q;     // Sticky order fault
  logic [5:0] supp_q;      // Suppressed channels, bit 0 = channel 1
  logic       run_q, run_d;  // Run request, last and present sample
  logic [15:0] ms_q;       // Elapsed whole milliseconds
  logic [19:0] cyc_q;      // Cycles within one millisecond
  logic       win_q;       // Mask window open
  logic [3:0] lr_w, lo_w;  // Log ready and overrun pairs
  logic       tsr_w, tso_w;  // Timestamp ready and overrun
  // ==========================================================
  // Address decode
  wire hit_cut  = reg_addr == ROL_OFS_CUTOFF;
  wire hit_st   = reg_addr == ROL_OFS_SELFTEST;
  wire hit_log  = reg_addr == ROL_OFS_LOGCTL;
  wire hit_rise = reg_addr == ROL_OFS_RISEMSK;
  wire hit_fall = reg_addr == ROL_OFS_FALLMSK;
  wire wr_log   = reg_wr & hit_log;
  // Invalid cutoff codes are refused, the old choice stays
  wire cut_ok   = reg_wdata[2:0] >= ROL_CUTOFF_MIN && reg_wdata[2:0] <= ROL_CUTOFF_MAX;
  // Releases honoured only when overwrite is off
  wire [3:0] rel_d = {4{wr_log & ~log_overwrite_allow}} &
                     {reg_wdata[ROL_BIT_ON_REL], reg_wdata[ROL_BIT_OFF_REL],
                      reg_wdata[ROL_BIT_WAKE_REL], reg_wdata[ROL_BIT_DOZE_REL]};
  wire tsrel_d  = wr_log & ~timestamp_overwrite_allow & reg_wdata[ROL_BIT_TS_REL];
  // Strobe bits always read zero; reserved read zero
  wire [7:0] rd_w = hit_cut  ? {5'h00, cut_q} :
                    hit_st   ? {st_q, 7'h00} :
                    hit_log  ? {1'b0, sel_q, 5'h00} :
                    hit_rise ? {2'h0, rmsk_q} :
                    hit_fall ? {2'h0, fmsk_q} : 8'h00;
  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cut_q  <= ROL_CUTOFF_RST;
      st_q   <= 1'b0;
      sel_q  <= ROL_SEL_RST;
      rmsk_q <= ROL_MASK_RST;
      fmsk_q <= ROL_MASK_RST;
    end else if (reg_wr) begin
      if (hit_cut && cut_ok) cut_q <= reg_wdata[2:0];
      if (hit_st) st_q <= reg_wdata[ROL_BIT_SELFTEST];
      if (hit_log) sel_q <= reg_wdata[ROL_SEL_HI:ROL_SEL_LO];
      if (hit_rise) rmsk_q <= reg_wdata[5:0];
      if (hit_fall) fmsk_q <= reg_wdata[5:0];
    end
  end
  // ==========================================================
  // One-cycle strobes and read data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_q  <= 1'b0;
      rel_q   <= 4'h0;
      tsrel_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      trig_q  <= wr_log & reg_wdata[ROL_BIT_TRIGGER];
      rel_q   <= rel_d;
      tsrel_q <= tsrel_d;
      if (reg_rd) rdata_q <= rd_w;
    end
  end
  // ==========================================================
  // Flag pairs, index 3 power-on .. 0 doze
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      rol_flag u_flag (
        .clk       (core_clk),
        .reset_n   (reset_n),
        .done      (log_done[gi]),
        .release_s (rel_q[gi]),
        .ready_q   (lr_w[gi]),
        .over_q    (lo_w[gi])
      );
    end
  endgenerate
  rol_flag u_ts (
    .clk       (core_clk),
    .reset_n   (reset_n),
    .done      (ts_done),
    .release_s (tsrel_q),
    .ready_q   (tsr_w),
    .over_q    (tso_w)
  );
  // ==========================================================
  // Sticky fault on order mismatch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) fault_q <= 1'b0;
    else if (order_mismatch) fault_q <= 1'b1;
  end
  // ==========================================================
  // Auto-mask window on run request edges
  // Pin idles low, so the cleared edge register gives no false edge
  assign run_d = run_request_pin;
  wire rise  = run_d & ~run_q;
  wire fall  = ~run_d & run_q;
  wire step  = cyc_q == 20'(ROL_STEP_CYC - 1);
  // A new edge restarts the window with the mask of that edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q  <= 1'b0;
      win_q  <= 1'b0;
      supp_q <= 6'h00;
      ms_q   <= 16'h0000;
      cyc_q  <= 20'h00000;
    end else begin
      run_q <= run_d;
      if (rise || fall) begin
        win_q  <= 1'b1;
        supp_q <= rise ? rmsk_q : fmsk_q;
        ms_q   <= 16'h0000;
        cyc_q  <= 20'h00000;
      end else if (win_q) begin
        cyc_q <= step ? 20'h00000 : cyc_q + 20'h00001;
        // Code zero means one millisecond
        if (step && ms_q == timeout_ms) begin
          win_q  <= 1'b0;
          supp_q <= 6'h00;
        end else if (step) begin
          ms_q <= ms_q + 16'h0001;
        end
      end
    end
  end
  // ==========================================================
  // Output drive
  assign slow_path_cutoff_select = cut_q;
  assign selftest_go       = st_q;
  assign record_trigger    = trig_q;
  assign transition_select = rol_trans_t'(sel_q);
  assign log_ready         = lr_w;
  assign log_overrun       = lo_w;
  assign timestamp_ready   = tsr_w;
  assign timestamp_overrun = tso_w;
  assign order_fault       = fault_q;
  assign irq_suppress      = supp_q;
  assign reg_rdata         = rdata_q;
  // ==========================================================
  // Checks
  // Trigger write, then its strobe in the following cycle
  sequence s_trig_wr;
    wr_log && reg_wdata[ROL_BIT_TRIGGER];
  endsequence
  sequence s_trig_seen;
    record_trigger;
  endsequence
  a_trig_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_trig_wr |=> s_trig_seen) else $error("trigger missed");
  // Back-to-back trigger writes legally keep the strobe up
  a_trig_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    (record_trigger && !(wr_log && reg_wdata[ROL_BIT_TRIGGER])) |=> !record_trigger)
    else $error("trigger held");
  a_rel_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wr_log && log_overwrite_allow) |=> rel_q == 4'h0) else $error("release leaked");
  // Release without a same-cycle completion empties the pair
  property p_log_clear;
    @(posedge core_clk) disable iff (!reset_n)
    ((rel_q & ~log_done) != 4'h0) |=>
      ((log_ready | log_overrun) & $past(rel_q & ~log_done)) == 4'h0;
  endproperty
  a_log_clear: assert property (p_log_clear)
    else $error("log not cleared");
  a_ts_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    (tsrel_q && !ts_done) |=> !timestamp_ready && !timestamp_overrun)
    else $error("timestamp not cleared");
  a_rd_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && hit_log) |=> reg_rdata[4:0] == 5'h00 && !reg_rdata[7])
    else $error("strobe bits read back");
  a_cut_valid: assert property (@(posedge core_clk) disable iff (!reset_n)
    cut_q >= ROL_CUTOFF_MIN && cut_q <= ROL_CUTOFF_MAX) else $error("bad cutoff");
  a_rise_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    rise |=> irq_suppress == $past(rmsk_q)) else $error("rise mask");
  a_fall_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    fall |=> irq_suppress == $past(fmsk_q)) else $error("fall mask");
  // Last millisecond step of the window lifts every mask
  a_mask_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    (win_q && step && ms_q == timeout_ms && !(rise || fall)) |=> irq_suppress == 6'h00)
    else $error("mask not released");
  a_st_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && hit_st) |=> selftest_go == $past(reg_wdata[ROL_BIT_SELFTEST]))
    else $error("selftest");
  a_fault_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    order_mismatch |=> order_fault [*2]) else $error("fault lost");
  a_sel_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_log |=> sel_q == $past(reg_wdata[6:5])) else $error("select");
endmodule : rol_ctl

// *** verification/rol_host.sv ***
// Host-side model: byte register master for the control bank.
// Assumes the bank samples reg_wr or reg_rd on the core_clk rising edge.
`timescale 1ns/1ns
module rol_host (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ==========================================================
  // Idle levels at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write, held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // Stale data must not look valid
    #1;
  endtask : wr
  // One read, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : rol_host

// *** verification/rol_ctl_tb.sv ***
// Self-checking bench for the order log and auto-mask register bank.
// Assumes the host model drives the register port; one 10 MHz clock.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module rol_ctl_tb;
  import rol_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        reg_wr, reg_rd, selftest_go, record_trigger, order_fault;
  logic  [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic        timestamp_overwrite_allow = 1'b0, log_overwrite_allow = 1'b0;
  logic [15:0] timeout_ms = 16'h0000;
  logic        run_request_pin = 1'b0, sleep_pin = 1'b0;  // Sleep unused here
  logic  [3:0] log_done = 4'h0, log_ready, log_overrun;
  logic        ts_done = 1'b0, order_mismatch = 1'b0;
  logic        timestamp_ready, timestamp_overrun;
  logic  [2:0] slow_path_cutoff_select, cut_exp;
  logic  [5:0] irq_suppress, mk;
  rol_trans_t  transition_select;
  int          error_cnt = 0, n_checks = 0, cnt, span;
  always #50 core_clk = ~core_clk;
  rol_ctl rol_ctl_i (.core_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .timestamp_overwrite_allow, .log_overwrite_allow, .timeout_ms,
    .run_request_pin, .sleep_pin, .log_done, .ts_done, .order_mismatch,
    .slow_path_cutoff_select, .selftest_go, .record_trigger, .transition_select,
    .log_ready, .log_overrun, .timestamp_ready, .timestamp_overrun, .order_fault,
    .irq_suppress);
  rol_host rol_host_i (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  // ==========================================================
  // Verdict, reached from the sequence or the watchdog
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // One-cycle event pulse: 0..3 log, 4 timestamp, 5 order mismatch
  task automatic ev(input int i);
    @(posedge core_clk);
    if (i == 4) ts_done <= 1'b1;
    else if (i == 5) order_mismatch <= 1'b1;
    else log_done[i] <= 1'b1;
    @(posedge core_clk);
    {ts_done, order_mismatch, log_done} <= 6'h00;
    #1;
  endtask : ev
  // Ready and overrun pair of one log (4 = timestamp)
  function automatic logic [1:0] flg(input int i);
    return (i == 4) ? {timestamp_ready, timestamp_overrun} : {log_ready[i], log_overrun[i]};
  endfunction : flg
  // Only codes 2..6 are accepted; others keep the old choice
  function automatic logic [2:0] cut_next(input logic [2:0] o, input logic [2:0] c);
    return (c >= ROL_CUTOFF_MIN && c <= ROL_CUTOFF_MAX) ? c : o;
  endfunction : cut_next
  // Watchdog: run needs under 50000 cycles
  initial begin
    #(100 * 80000);
    error_cnt++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(90089));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    // Reset values, unmapped read
    rol_host_i.rd(ROL_OFS_CUTOFF, rv);
    `CHK("cutoff rst", 3'h4, rv[2:0])
    rol_host_i.rd(ROL_OFS_LOGCTL, rv);
    `CHK("logctl rst", 8'h00, rv)
    for (int e = 0; e < 2; e++) begin
      rol_host_i.rd(ROL_OFS_RISEMSK + e[7:0], rv);
      `CHK("mask rst", 6'h3F, rv[5:0])
    end
    rol_host_i.rd(8'h10, rv);
    `CHK("unmapped", 8'h00, rv)
    $display("test reset done");
    // Every cutoff code, reserved bits set
    cut_exp = 3'h4;
    for (int c = 0; c < 8; c++) begin
      rol_host_i.wr(ROL_OFS_CUTOFF, {5'h1F, c[2:0]});
      cut_exp = cut_next(cut_exp, c[2:0]);
      `CHK("cutoff", cut_exp, slow_path_cutoff_select)
      rol_host_i.rd(ROL_OFS_CUTOFF, rv);
      `CHK("cutoff rd", cut_exp, rv[2:0])
    end
    $display("test cutoff done");
    // Self-test entry and leave
    rol_host_i.wr(ROL_OFS_SELFTEST, 8'h80);
    `CHK("selftest on", 1'b1, selftest_go)
    rol_host_i.wr(ROL_OFS_SELFTEST, 8'h7F);
    `CHK("selftest off", 1'b0, selftest_go)
    // Trigger with every transition kind
    for (int s = 0; s < 4; s++) begin
      rol_host_i.wr(ROL_OFS_LOGCTL, {1'b1, s[1:0], 5'h00});
      `CHK("trigger", 1'b1, record_trigger)
      `CHK("select", s[1:0], transition_select)
      @(posedge core_clk);
      #1;
      `CHK("trigger pulse", 1'b0, record_trigger)
      rol_host_i.rd(ROL_OFS_LOGCTL, rv);
      `CHK("logctl rd", {1'b0, s[1:0], 5'h00}, rv)
    end
    $display("test trigger done");
    // Flags: set, overrun, release refused, release taken
    for (int i = 0; i < 5; i++) begin
      ev(i);
      ev(i);
      `CHK("flags set", 2'b11, flg(i))
      // Only the overwrite control that governs this pair is raised
      @(posedge core_clk);
      {timestamp_overwrite_allow, log_overwrite_allow} <= (i == 4) ? 2'b10 : 2'b01;
      rol_host_i.wr(ROL_OFS_LOGCTL, 8'h01 << i);
      // Release strobe reaches the flags one cycle after the write
      @(posedge core_clk);
      #1;
      `CHK("release off", 2'b11, flg(i))
      @(posedge core_clk);
      {timestamp_overwrite_allow, log_overwrite_allow} <= 2'b00;
      rol_host_i.wr(ROL_OFS_LOGCTL, 8'h01 << i);
      @(posedge core_clk);
      #1;
      `CHK("release", 2'b00, flg(i))
    end
    ev(5);
    `CHK("order fault", 1'b1, order_fault)
    $display("test flags done");
    // Auto-mask on rise then fall, random mask and timeout
    for (int e = 0; e < 2; e++) begin
      mk = 6'($urandom_range(1, 63));
      rol_host_i.wr(ROL_OFS_RISEMSK + e[7:0], {2'b11, mk});
      @(posedge core_clk);
      timeout_ms <= 16'($urandom_range(0, 1));
      run_request_pin <= (e == 0);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("suppress", mk, irq_suppress)
      cnt = 3;
      while (irq_suppress !== 6'h00 && cnt < 30000) begin
        @(posedge core_clk);
        #1;
        cnt++;
      end
      span = (timeout_ms + 1) * ROL_STEP_CYC;
      `CHK("span", 1'b1, (cnt >= span - 2 && cnt <= span + 4))
    end
    $display("test automask done");
    complete_run();
  end
endmodule : rol_ctl_tb
